// ---- hdl/asr_receiver.sv ----
// ascii string receiver on the second serial port
// Operation
// - port is receive or transmit only, never both at once
// - strings go to consecutive words from destination, two characters per word
// - fixed mode takes exactly the set count of 1 to 128 bytes
// - fixed mode sets complete after last byte, cleared by dropping permissive
// - busy stays high while a string is being received
// - gap between characters longer than limit raises inter-character error
// - a string cut by inter-character timeout is never stored
// - inter-character error clears only when permissive drops or the port is set to transmit
// - no first character within limit sets first error, cleared by permissive
// - a limit of zero milliseconds disables that timeout
// - byte exchange per word: none, all, or all but null
// - variable mode takes strings up to max length, ended by terminator
// - terminator is one or two set character values
// - variable mode sets complete at terminator, cleared by permissive
// - variable mode sets overflow when bytes exceed the max length
`timescale 1ns/1ns
module asr_receiver
  import asr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = ASR_MS_CYCLES
) (
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic         PERMISSIVE,
  input  wire asr_port_op_t SECOND_PORT_SELECT,
  input  wire asr_cfg_t     CFG,
  input  wire logic [7:0]   RX_DATA,
  input  wire logic         RX_VALID,
  output logic              RX_READY,
  output logic              TX_ENABLE,
  output asr_flags_t        FLAGS,
  output asr_wr_t           MEM_WR
);
  asr_state_t              state_reg, state_next;
  logic [7:0]              cnt_reg, cnt_next;
  logic [63:0]             acc_reg, acc_next;
  logic [7:0]              prev_reg, prev_next;
  logic [ASR_PRE_W-1:0]    pre_reg, pre_next;
  logic [15:0]             ms_reg, ms_next;
  asr_flags_t              flags_reg, flags_next;
  logic [6:0]              left_reg, left_next;
  logic [1:0]              sub_reg, sub_next;
  logic [15:0]             waddr_reg, waddr_next;
  asr_wr_t                 wr_reg, wr_next;
  logic                    rx_ready_reg, rx_ready_next;
  logic                    tx_en_reg, tx_en_next;

  logic                    enable;
  logic                    take;
  logic                    term_hit;
  logic                    end_str;
  logic [7:0]              eff_len;
  logic [63:0]             push_src;
  logic [63:0]             push_data;
  logic                    push;
  logic                    pop;
  logic                    fifo_in_ready;
  logic [ASR_FIFO_W-1:0]   fifo_out;
  logic                    fifo_out_valid;
  logic                    flush;

  // only an armed receive-mode port accepts characters
  assign enable = PERMISSIVE && (SECOND_PORT_SELECT == ASR_STRING_RECEIVE_OP);
  assign flush  = (state_reg == ASR_IDLE) || (state_reg == ASR_ERR);

  // out-of-range lengths are pulled into 1..128
  assign eff_len = (CFG.length == 8'h00) ? ASR_MIN_LEN :
                   (CFG.length > ASR_MAX_LEN) ? ASR_MAX_LEN : CFG.length;

  // per-word exchange of the entry going into the fifo
  genvar gi;
  generate
    for (gi = 0; gi < ASR_WPE; gi++) begin : g_swap
      logic [15:0] w;
      logic        do_swap;
      assign w       = push_src[gi*16 +: 16];
      assign do_swap = (CFG.byte_exchange_op == ASR_SWAP_ALL) ||
                       ((CFG.byte_exchange_op == ASR_SWAP_NONNULL) &&
                        (w[15:8] != 8'h00) && (w[7:0] != 8'h00));
      assign push_data[gi*16 +: 16] = do_swap ? {w[7:0], w[15:8]} : w;
    end
  endgenerate

  asr_fifo #(
    .WIDTH (ASR_FIFO_W),
    .DEPTH (ASR_FIFO_D)
  ) u_fifo (
    .clk       (CLK),
    .rst       (RESET),
    .flush     (flush),
    .in_data   (push_data),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (pop)
  );

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    acc_next   = acc_reg;
    prev_next  = prev_reg;
    flags_next = flags_reg;
    left_next  = left_reg;
    sub_next   = sub_reg;
    waddr_next = waddr_reg;
    wr_next    = wr_reg;
    wr_next.we = 1'b0;
    push_src   = acc_reg;
    push       = 1'b0;
    pop        = 1'b0;
    end_str    = 1'b0;
    take       = rx_ready_reg && RX_VALID;
    // two-character code needs the previous byte of this string
    term_hit   = CFG.two_term ? ((cnt_reg != 8'h00) && (prev_reg == CFG.term1) &&
                                 (RX_DATA == CFG.term2))
                              : (RX_DATA == CFG.term1);
    // millisecond timebase, restarted on each character
    if (pre_reg == ASR_PRE_W'(MS_CYCLES - 1)) begin
      pre_next = '0;
      ms_next  = (ms_reg == 16'hffff) ? ms_reg : ms_reg + 16'h0001;
    end else begin
      pre_next = pre_reg + 1'b1;
      ms_next  = ms_reg;
    end
    case (state_reg)
      ASR_IDLE: begin
        flags_next = '0;
        cnt_next   = 8'h00;
        acc_next   = '0;
        if (enable) begin
          state_next = ASR_WAIT;
          pre_next   = '0;
          ms_next    = 16'h0000;
        end
      end
      ASR_WAIT, ASR_RECV: begin
        if (take) begin
          state_next = ASR_RECV;
          pre_next   = '0;
          ms_next    = 16'h0000;
          prev_next  = RX_DATA;
          if (!CFG.fixed_mode && (cnt_reg == eff_len)) begin
            // byte past max is dropped, what fits is kept
            flags_next.overflow = 1'b1;
            end_str             = 1'b1;
            push                = (cnt_reg[2:0] != 3'h0);
          end else begin
            // low byte first, two characters to a word
            acc_next = acc_reg | (64'(RX_DATA) << {cnt_reg[2:0], 3'h0});
            cnt_next = cnt_reg + 8'h01;
            end_str  = CFG.fixed_mode ? (cnt_next == eff_len) : term_hit;
            push_src = acc_next;
            push     = (cnt_reg[2:0] == 3'h7) || end_str;
            if (push) begin
              acc_next = '0;
            end
          end
          if (end_str) begin
            state_next = ASR_COMMIT;
            left_next  = 7'((9'(cnt_next) + 9'h001) >> 1);
            sub_next   = 2'h0;
            waddr_next = CFG.dest;
          end
        end else if (state_reg == ASR_WAIT) begin
          if ((CFG.first_ms != 16'h0000) && (ms_reg >= CFG.first_ms)) begin
            flags_next.first_err = 1'b1;
            state_next           = ASR_ERR;
          end
        end else if ((CFG.ichar_ms != 16'h0000) && (ms_reg >= CFG.ichar_ms)) begin
          // fifo flush in the error state discards the partial string
          flags_next.ichar_err = 1'b1;
          state_next           = ASR_ERR;
        end
      end
      ASR_COMMIT: begin
        // fifo only drains after the whole string is in, so nothing partial lands
        if (left_reg == 7'h00) begin
          state_next          = ASR_DONE;
          flags_next.complete = !flags_reg.overflow;
        end else if (fifo_out_valid) begin
          wr_next.we   = 1'b1;
          wr_next.addr = waddr_reg;
          wr_next.data = fifo_out[{sub_reg, 4'h0} +: 16];
          waddr_next   = waddr_reg + 16'h0001;
          left_next    = left_reg - 7'h01;
          pop          = (sub_reg == 2'h3) || (left_reg == 7'h01);
          sub_next     = pop ? 2'h0 : sub_reg + 2'h1;
        end
      end
      ASR_DONE, ASR_ERR: begin
        state_next = state_reg;
      end
      default: begin
        state_next = ASR_IDLE;
      end
    endcase
    // flags and state only fall back here, when the program drops permissive or selects transmit
    if (!enable) begin
      state_next = ASR_IDLE;
      flags_next = '0;
    end
    flags_next.busy = (state_next == ASR_RECV) || (state_next == ASR_COMMIT);
    rx_ready_next   = ((state_next == ASR_WAIT) || (state_next == ASR_RECV)) && fifo_in_ready;
    tx_en_next      = (SECOND_PORT_SELECT == ASR_STRING_TRANSMIT_OP);
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg    <= ASR_IDLE;
      cnt_reg      <= 8'h00;
      acc_reg      <= '0;
      prev_reg     <= 8'h00;
      pre_reg      <= '0;
      ms_reg       <= 16'h0000;
      flags_reg    <= '0;
      left_reg     <= 7'h00;
      sub_reg      <= 2'h0;
      waddr_reg    <= 16'h0000;
      wr_reg       <= '0;
      rx_ready_reg <= 1'b0;
      tx_en_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      acc_reg      <= acc_next;
      prev_reg     <= prev_next;
      pre_reg      <= pre_next;
      ms_reg       <= ms_next;
      flags_reg    <= flags_next;
      left_reg     <= left_next;
      sub_reg      <= sub_next;
      waddr_reg    <= waddr_next;
      wr_reg       <= wr_next;
      rx_ready_reg <= rx_ready_next;
      tx_en_reg    <= tx_en_next;
    end
  end

  assign RX_READY  = rx_ready_reg;
  assign TX_ENABLE = tx_en_reg;
  assign FLAGS     = flags_reg;
  assign MEM_WR    = wr_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_port_one_way: assert property (TX_ENABLE |-> !RX_READY)
    else $error("receiver ready while port owned by transmit");
  chk_words_consec: assert property (MEM_WR.we ##1 MEM_WR.we |->
                                     MEM_WR.addr == $past(MEM_WR.addr) + 16'h0001)
    else $error("stored words not consecutive");
  chk_store_bound: assert property (MEM_WR.we |-> (MEM_WR.addr - CFG.dest) < 16'h0040)
    else $error("store beyond 64 words");
  chk_complete_hold: assert property (FLAGS.complete && PERMISSIVE |=> FLAGS.complete)
    else $error("complete dropped while armed");
  chk_busy_span: assert property (take && state_reg == ASR_WAIT && enable |=> FLAGS.busy)
    else $error("busy not raised on first character");
  chk_no_store_err: assert property (FLAGS.ichar_err |-> !MEM_WR.we)
    else $error("store after inter-character timeout");
  chk_flags_clear: assert property (!PERMISSIVE |=> !FLAGS.complete && !FLAGS.ichar_err &&
                                    !FLAGS.first_err && !FLAGS.overflow)
    else $error("flags survive dropped permissive");
  chk_first_limit: assert property ($rose(FLAGS.first_err) |->
                                    $past(ms_reg) >= $past(CFG.first_ms))
    else $error("first timeout before its limit");
  chk_zero_limit: assert property ($rose(FLAGS.ichar_err) |-> $past(CFG.ichar_ms) != 16'h0000)
    else $error("timeout raised with zero limit");
  chk_ovf_variable: assert property ($rose(FLAGS.overflow) |-> !$past(CFG.fixed_mode))
    else $error("overflow in fixed mode");
  chk_ovf_count: assert property (FLAGS.overflow |-> cnt_reg == eff_len)
    else $error("overflow before the max length");

  // timeouts only after the limit, never with a zero limit
  chk_ichar_limit: assert property ($rose(FLAGS.ichar_err) |->
                                    $past(ms_reg) >= $past(CFG.ichar_ms))
    else $error("inter-character timeout before its limit");
  chk_first_zero: assert property ($rose(FLAGS.first_err) |->
                                   $past(CFG.first_ms) != 16'h0000)
    else $error("first timeout raised with zero limit");
  chk_err_idle: assert property (FLAGS.ichar_err || FLAGS.first_err |->
                                 !FLAGS.busy && !RX_READY && !MEM_WR.we)
    else $error("receiver still active after timeout");

  // exchange only touches the words it is allowed to
  chk_swap_none: assert property (push && CFG.byte_exchange_op == ASR_SWAP_NONE |->
                                  push_data == push_src)
    else $error("word exchanged with exchange off");
  chk_swap_all: assert property (push && CFG.byte_exchange_op == ASR_SWAP_ALL |->
                                 push_data[15:0] == {push_src[7:0], push_src[15:8]})
    else $error("word not exchanged with exchange on");
  chk_swap_null: assert property (push && CFG.byte_exchange_op == ASR_SWAP_NONNULL &&
                                  (push_src[7:0] == 8'h00 || push_src[15:8] == 8'h00) |->
                                  push_data[15:0] == push_src[15:0])
    else $error("word with null exchanged");

  // terminator detection in variable mode
  chk_term_one: assert property (take && enable && !CFG.fixed_mode && !CFG.two_term &&
                                 RX_DATA == CFG.term1 && cnt_reg != eff_len |=>
                                 state_reg == ASR_COMMIT)
    else $error("single terminator did not end the string");
  chk_term_pair: assert property (take && enable && !CFG.fixed_mode && CFG.two_term &&
                                  cnt_reg != 8'h00 && cnt_reg != eff_len &&
                                  prev_reg == CFG.term1 && RX_DATA == CFG.term2 |=>
                                  state_reg == ASR_COMMIT)
    else $error("two-character terminator did not end the string");
  chk_term_half: assert property (take && enable && !CFG.fixed_mode && CFG.two_term &&
                                  RX_DATA != CFG.term2 && cnt_reg != eff_len |=>
                                  state_reg == ASR_RECV)
    else $error("half a terminator ended the string");
  chk_var_complete: assert property (state_reg == ASR_DONE && !CFG.fixed_mode |->
                                     FLAGS.complete || FLAGS.overflow)
    else $error("variable string done without complete");
  chk_fixed_count: assert property (FLAGS.complete && CFG.fixed_mode |->
                                    cnt_reg == eff_len)
    else $error("fixed string ended at the wrong count");
endmodule

// ---- hdl/asr_pkg.sv ----
// shared constants and types for the ascii string receiver
package asr_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned ASR_MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned ASR_PRE_W     = $clog2(ASR_MS_CYCLES + 1);
  localparam int unsigned ASR_FIFO_W    = 64;
  localparam int unsigned ASR_FIFO_D    = 16;
  localparam int unsigned ASR_WPE       = 4;
  localparam logic [7:0]  ASR_MAX_LEN   = 8'h80;
  localparam logic [7:0]  ASR_MIN_LEN   = 8'h01;

  typedef enum logic [1:0] {ASR_SWAP_NONE, ASR_SWAP_ALL, ASR_SWAP_NONNULL} asr_swap_t;
  typedef enum logic {ASR_STRING_TRANSMIT_OP, ASR_STRING_RECEIVE_OP} asr_port_op_t;
  typedef enum logic [2:0] {ASR_IDLE, ASR_WAIT, ASR_RECV, ASR_COMMIT, ASR_DONE, ASR_ERR} asr_state_t;

  typedef struct packed {
    logic        fixed_mode;
    logic [7:0]  length;
    logic        two_term;
    logic [7:0]  term1;
    logic [7:0]  term2;
    asr_swap_t   byte_exchange_op;
    logic [15:0] ichar_ms;
    logic [15:0] first_ms;
    logic [15:0] dest;
  } asr_cfg_t;

  typedef struct packed {
    logic busy;
    logic complete;
    logic ichar_err;
    logic first_err;
    logic overflow;
  } asr_flags_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } asr_wr_t;
endpackage

// ---- hdl/asr_fifo.sv ----
// word fifo with registered read data
`timescale 1ns/1ns
module asr_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic             out_valid_reg, out_valid_next;
  logic             push;
  logic             load;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_data  = out_data_reg;
  assign out_valid = out_valid_reg;

  always_comb begin
    push           = in_valid && in_ready && !flush;
    load           = (count_reg != '0) && (!out_valid_reg || out_ready) && !flush;
    wr_ptr_next    = wr_ptr_reg;
    rd_ptr_next    = rd_ptr_reg;
    count_next     = count_reg;
    out_data_next  = out_data_reg;
    out_valid_next = out_valid_reg;
    if (flush) begin
      wr_ptr_next    = '0;
      rd_ptr_next    = '0;
      count_next     = '0;
      out_valid_next = 1'b0;
    end else begin
      if (push) begin
        wr_ptr_next = wr_ptr_reg + 1'b1;
      end
      if (load) begin
        out_data_next  = mem[rd_ptr_reg];
        out_valid_next = 1'b1;
        rd_ptr_next    = rd_ptr_reg + 1'b1;
      end else if (out_ready) begin
        out_valid_next = 1'b0;
      end
      count_next = count_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // storage has no reset; only pointers define contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_data_reg  <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      out_data_reg  <= out_data_next;
      out_valid_reg <= out_valid_next;
    end
  end
endmodule

// ---- verif/asr_src.sv ----
// behavioural ascii character source facing the receiver
`timescale 1ns/1ns
module asr_src (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid
);
  logic [7:0] q[$];
  int         gap = 0;
  int         wait_cnt = 0;
  logic       tk;
  logic       nv;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  always @(posedge clk) begin
    tk = rx_valid && rx_ready;
    #1;
    if (tk) begin
      void'(q.pop_front());
      wait_cnt = gap;
    end else if (wait_cnt > 0) begin
      wait_cnt--;
    end
    nv = (q.size() > 0) && ((rx_valid && !tk) || wait_cnt == 0);
    // idle data keeps toggling so a stale character is never mistaken for a valid one
    rx_data = nv ? q[0] : ~rx_data;
    rx_valid = nv;
  end
  task automatic push(input logic [7:0] c);
    q.push_back(c);
  endtask
  task automatic flush();
    q.delete();
  endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the ascii string receiver
`timescale 1ns/1ns
module tb;
  import asr_pkg::*;
  localparam int unsigned MSC = 10;
  logic         clk;
  logic         reset;
  logic         permissive;
  asr_port_op_t port_sel;
  asr_cfg_t     cfg;
  logic [7:0]   rx_data;
  logic         rx_valid;
  logic         rx_ready;
  logic         tx_enable;
  asr_flags_t   flags;
  asr_wr_t      mem_wr;
  int           failures;
  int           check_count;
  logic [31:0]  wq[$];
  logic [31:0]  eq[$];
  asr_receiver #(.MS_CYCLES(MSC)) i_dut (.CLK(clk), .RESET(reset), .PERMISSIVE(permissive),
    .SECOND_PORT_SELECT(port_sel), .CFG(cfg), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .TX_ENABLE(tx_enable), .FLAGS(flags), .MEM_WR(mem_wr));
  asr_src i_src (.clk(clk), .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (mem_wr.we === 1'b1) wq.push_back({mem_wr.addr, mem_wr.data});
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic asr_cfg_t mk(logic fx, logic [7:0] len, logic two, logic [7:0] t1,
    asr_swap_t sw, logic [15:0] ich, logic [15:0] fst, logic [15:0] dst);
    return '{fx, len, two, t1, 8'h0a, sw, ich, fst, dst};
  endfunction
  task automatic arm(input asr_cfg_t c);
    permissive = 1'b0;
    cyc(2);
    chk(flags, '0, "flags after permissive low");
    i_src.flush();
    cfg = c;
    wq.delete();
    eq.delete();
    permissive = 1'b1;
  endtask
  task automatic send(input string s);
    foreach (s[i]) i_src.push(s[i]);
  endtask
  task automatic wait_end();
    int i;
    for (i = 0; i < 600 && !(flags.complete | flags.ichar_err | flags.first_err
         | flags.overflow); i++) cyc(1);
    if (i == 600) begin
      failures++;
      $display("unexpected at %0t: string never ended", $time);
      end_sim();
    end
    // overflow may be flagged before the kept words drain
    cyc(12);
  endtask
  task automatic cmp_mem();
    chk(wq.size(), eq.size(), "word count");
    foreach (eq[i]) if (i < wq.size()) chk(wq[i], eq[i], "stored word");
  endtask
  task automatic t_port();
    permissive = 1'b1;
    port_sel = ASR_STRING_TRANSMIT_OP;
    send("x");
    cyc(4);
    chk(tx_enable, 1'b1, "transmit owns port");
    chk(rx_ready, 1'b0, "no receive in transmit mode");
    permissive = 1'b0;
    port_sel = ASR_STRING_RECEIVE_OP;
    cyc(3);
    chk(tx_enable, 1'b0, "transmit released");
    $display("test port select done");
  endtask
  task automatic t_fixed();
    int i;
    arm(mk(1, 8'h03, 0, 8'h0d, ASR_SWAP_NONE, 16'h0, 16'h0, 16'h0100));
    i_src.gap = 30;
    send("abcd");
    for (i = 0; i < 100 && flags.busy !== 1'b1; i++) cyc(1);
    if (i == 100) begin
      failures++;
      $display("unexpected at %0t: busy never rose", $time);
      end_sim();
    end
    cyc(15);
    chk(flags.busy, 1'b1, "busy mid string");
    wait_end();
    chk(flags.complete, 1'b1, "complete after count");
    chk(flags.busy, 1'b0, "busy after string");
    chk(i_src.q.size(), 1, "extra character left");
    eq = '{32'h01006261, 32'h01010063};
    cmp_mem();
    i_src.gap = 0;
    $display("test fixed done");
  endtask
  task automatic t_long();
    arm(mk(1, 8'h80, 0, 8'h0d, ASR_SWAP_NONE, 16'h0, 16'h0, 16'h1000));
    for (int k = 0; k < 128; k++) i_src.push(8'(k + 1));
    for (int k = 0; k < 64; k++) eq.push_back({16'(16'h1000 + k), 8'(2 * k + 2), 8'(2 * k + 1)});
    wait_end();
    chk(flags.complete, 1'b1, "complete at 128");
    cmp_mem();
    $display("test long fixed done");
  endtask
  task automatic t_var();
    arm(mk(0, 8'h08, 0, 8'h0d, ASR_SWAP_ALL, 16'h0, 16'h0, 16'h0200));
    send("A\015B\015\n");
    wait_end();
    chk(flags.complete, 1'b1, "one char terminator");
    eq = '{32'h0200410d};
    cmp_mem();
    arm(mk(0, 8'h08, 1, 8'h0d, ASR_SWAP_ALL, 16'h0, 16'h0, 16'h0200));
    send("A\015B\015\n");
    wait_end();
    chk(flags.complete, 1'b1, "two char terminator");
    eq = '{32'h0200410d, 32'h0201420d, 32'h02020a00};
    cmp_mem();
    arm(mk(1, 8'h04, 0, 8'h0d, ASR_SWAP_NONNULL, 16'h0, 16'h0, 16'h0300));
    send("A");
    i_src.push(8'h00);
    send("CD");
    wait_end();
    eq = '{32'h03000041, 32'h03014344};
    cmp_mem();
    $display("test variable and exchange done");
  endtask
  task automatic t_over();
    arm(mk(0, 8'h02, 0, 8'h0d, ASR_SWAP_NONE, 16'h0, 16'h0, 16'h0400));
    send("ABC");
    wait_end();
    chk(flags.overflow, 1'b1, "overflow");
    chk(flags.complete, 1'b0, "no complete on overflow");
    eq = '{32'h04004241};
    cmp_mem();
    $display("test overflow done");
  endtask
  task automatic t_timeouts();
    arm(mk(1, 8'h04, 0, 8'h0d, ASR_SWAP_NONE, 16'h1, 16'h0, 16'h0500));
    i_src.gap = 40;
    send("abcd");
    wait_end();
    chk(flags.ichar_err, 1'b1, "gap too long");
    chk(flags.complete, 1'b0, "no complete on gap");
    cmp_mem();
    i_src.gap = 0;
    arm(mk(1, 8'h01, 0, 8'h0d, ASR_SWAP_NONE, 16'h0, 16'h0, 16'h0600));
    cyc(100);
    chk(flags.first_err, 1'b0, "zero limit never fires");
    arm(mk(1, 8'h01, 0, 8'h0d, ASR_SWAP_NONE, 16'h0, 16'h1, 16'h0600));
    wait_end();
    chk(flags.first_err, 1'b1, "first char late");
    cmp_mem();
    arm(cfg);
    $display("test timeouts done");
  endtask
  initial begin
    failures = 0;
    check_count = 0;
    reset = 1'b1;
    permissive = 1'b0;
    port_sel = ASR_STRING_RECEIVE_OP;
    cfg = '0;
    cyc(2);
    reset = 1'b0;
    cyc(1);
    chk({flags, mem_wr.we, rx_ready}, '0, "outputs after reset");
    t_port();
    t_fixed();
    t_long();
    t_var();
    t_over();
    t_timeouts();
    end_sim();
  end
endmodule
